//--- hdl/fspc_host.sv
// Host controller that reads, loads and polls a parallel sector flash.
// Assumes an AHB-Lite master for the registers and flash pins on hclk.
`timescale 1ns/1ps
`default_nettype none

module fspc_host #(
	parameter int POWER_WAIT_CYC = fspc_pkg::POWER_WAIT_CYC,
	parameter int POLL_LIMIT_CYC = fspc_pkg::POLL_LIMIT_CYC
) (
	input wire logic hclk, // System clock
	input wire logic hresetn, // Asynchronous reset, active low
	input wire logic hsel, // Slave select
	input wire logic [31:0] haddr, // Byte address
	input wire logic [1:0] htrans, // Transfer type
	input wire logic hwrite, // Write when high
	input wire logic [2:0] hsize, // Word transfers only
	input wire logic [31:0] hwdata, // Write data
	input wire logic hready, // Bus ready
	output logic hreadyout, // Slave ready
	output logic [31:0] hrdata, // Read data
	output logic hresp, // Always OKAY
	output logic flash_ce_n, // Chip select
	output logic flash_oe_n, // Output enable
	output logic flash_we_n, // Write strobe
	output logic [15:0] flash_addr, // Word address
	input wire logic [15:0] flash_dq_in, // Data pins, sensed
	output logic [15:0] flash_dq_out, // Data pins, driven
	output logic flash_dq_oe // High while host drives data
);

	localparam int WIN_W = $clog2(fspc_pkg::LOAD_WINDOW_CYC + 1);
	localparam int PW_W = $clog2(POWER_WAIT_CYC + 1);
	localparam int TM_W = $clog2(POLL_LIMIT_CYC + 1);

	typedef struct packed {
		fspc_pkg::fspc_state_type st;
		fspc_pkg::fspc_op_type op;
		logic have_prev;
		logic [1:0] prev_tog;
		logic [15:0] addr;
		logic [15:0] wdata;
		logic [15:0] rdata;
		logic [8:0] sector;
		logic window_open;
		logic [WIN_W-1:0] win_cnt;
		logic dev_busy;
		logic [PW_W-1:0] pwr_cnt;
		logic [TM_W-1:0] tmo_cnt;
		logic err_refused;
		logic err_timeout;
		logic wr_pend;
		logic [7:0] wr_addr;
		logic hreadyout;
		logic [31:0] hrdata;
		logic hresp;
		logic ce_n;
		logic oe_n;
		logic we_n;
		logic [15:0] fa;
		logic [15:0] dq_out;
		logic dq_oe;
	} fspc_host_state_type;

	fspc_host_state_type r;
	fspc_host_state_type next_r;
	logic t_load;
	logic [2:0] t_value;
	logic t_expired;

	// Phase timer for strobe and access times
	fspc_timer #(.W(3)) u_timer (
		.hclk(hclk),
		.hresetn(hresetn),
		.load(t_load),
		.value(t_value),
		.expired(t_expired)
	);

	// Bus slave, command checks and pin sequencer
	always_comb begin
		logic [31:0] stat;
		logic start;
		logic refuse;
		logic pwr_wait;
		fspc_pkg::fspc_op_type cmd;
		stat = '0;
		start = 1'b0;
		refuse = 1'b0;
		pwr_wait = (r.pwr_cnt != '0);
		cmd = fspc_pkg::OP_NONE;
		next_r = r;
		next_r.hreadyout = 1'b1;
		next_r.hresp = 1'b0;
		next_r.wr_pend = 1'b0;
		t_load = 1'b0;
		t_value = '0;

		// Status word
		stat[fspc_pkg::ST_BUSY] = (r.st != fspc_pkg::S_IDLE);
		stat[fspc_pkg::ST_WINDOW] = r.window_open;
		stat[fspc_pkg::ST_DEV_BUSY] = r.dev_busy;
		stat[fspc_pkg::ST_POWER_WAIT] = pwr_wait;
		stat[fspc_pkg::ST_ERR_REFUSED] = r.err_refused;
		stat[fspc_pkg::ST_ERR_TIMEOUT] = r.err_timeout;

		// Address phase: latch writes, answer reads next cycle
		if (hsel && htrans[1] && hready) begin
			next_r.wr_pend = hwrite;
			next_r.wr_addr = haddr[7:0];
			if (!hwrite) begin
				unique case (haddr[7:0])
					fspc_pkg::REG_CMD: next_r.hrdata = {30'h0, r.op};
					fspc_pkg::REG_ADDR: next_r.hrdata = {16'h0, r.addr};
					fspc_pkg::REG_WDATA: next_r.hrdata = {16'h0, r.wdata};
					fspc_pkg::REG_RDATA: next_r.hrdata = {16'h0, r.rdata};
					fspc_pkg::REG_STATUS: next_r.hrdata = stat;
					default: next_r.hrdata = 32'h0;
				endcase
			end
		end

		// Data phase of a write
		if (r.wr_pend) begin
			unique case (r.wr_addr)
				fspc_pkg::REG_CMD: begin
					start = 1'b1;
					cmd = fspc_pkg::fspc_op_type'(hwdata[1:0]);
				end
				fspc_pkg::REG_ADDR: next_r.addr = hwdata[15:0];
				fspc_pkg::REG_WDATA: next_r.wdata = hwdata[15:0];
				fspc_pkg::REG_STATUS: begin
					if (hwdata[fspc_pkg::ST_ERR_REFUSED]) begin
						next_r.err_refused = 1'b0;
					end
					if (hwdata[fspc_pkg::ST_ERR_TIMEOUT]) begin
						next_r.err_timeout = 1'b0;
					end
				end
				default: ;
			endcase
		end

		// Power-up hold-off and poll time limit
		if (pwr_wait) begin
			next_r.pwr_cnt = r.pwr_cnt - 1'b1;
		end
		if (r.tmo_cnt != '0) begin
			next_r.tmo_cnt = r.tmo_cnt - 1'b1;
		end

		// Accept or refuse a command
		if (start) begin
			refuse = (r.st != fspc_pkg::S_IDLE) || (cmd == fspc_pkg::OP_NONE);
			if (cmd == fspc_pkg::OP_LOAD) begin
				refuse = refuse || pwr_wait || r.dev_busy;
				if (r.window_open) begin
					refuse = refuse || (r.win_cnt <= WIN_W'(fspc_pkg::LOAD_MARGIN_CYC))
						|| (r.addr[15:7] != r.sector);
				end
			end else if (cmd == fspc_pkg::OP_READ) begin
				refuse = refuse || r.dev_busy || r.window_open;
			end
			if (refuse) begin
				next_r.err_refused = 1'b1;
			end else begin
				next_r.op = cmd;
				next_r.st = fspc_pkg::S_SETUP;
				next_r.have_prev = 1'b0;
				next_r.tmo_cnt = TM_W'(POLL_LIMIT_CYC);
				next_r.fa = r.addr;
				next_r.dq_out = r.wdata;
				next_r.dq_oe = (cmd == fspc_pkg::OP_LOAD);
			end
		end

		// Pin sequencer; unlock and erase codes are ordinary loads
		unique case (r.st)
			fspc_pkg::S_IDLE: ;
			fspc_pkg::S_SETUP: begin
				next_r.ce_n = 1'b0;
				t_load = 1'b1;
				if (r.op == fspc_pkg::OP_LOAD) begin
					next_r.we_n = 1'b0;
					next_r.sector = r.fa[15:7];
					t_value = 3'(fspc_pkg::STROBE_CYC - 1);
				end else begin
					next_r.oe_n = 1'b0;
					t_value = 3'(fspc_pkg::READ_CYC - 1);
				end
				next_r.st = fspc_pkg::S_ACTIVE;
			end
			fspc_pkg::S_ACTIVE: begin
				if (t_expired) begin
					next_r.st = fspc_pkg::S_FINISH;
					next_r.we_n = 1'b1;
					next_r.oe_n = 1'b1;
					if (r.op == fspc_pkg::OP_LOAD) begin
						next_r.window_open = 1'b1;
						next_r.win_cnt = WIN_W'(fspc_pkg::LOAD_WINDOW_CYC);
					end else begin
						next_r.rdata = flash_dq_in;
					end
					if (r.op == fspc_pkg::OP_POLL) begin
						next_r.have_prev = 1'b1;
						next_r.prev_tog = {flash_dq_in[fspc_pkg::TOGGLE_BIT_HIGH_BYTE],
							flash_dq_in[fspc_pkg::TOGGLE_BIT_LOW_BYTE]};
						if (r.have_prev && next_r.prev_tog == r.prev_tog) begin
							next_r.dev_busy = 1'b0;
							next_r.op = fspc_pkg::OP_NONE;
						end else if (r.tmo_cnt == '0) begin
							next_r.err_timeout = 1'b1;
							next_r.op = fspc_pkg::OP_NONE;
						end
					end
				end
			end
			fspc_pkg::S_FINISH: begin
				next_r.ce_n = 1'b1;
				next_r.dq_oe = 1'b0;
				if (r.op == fspc_pkg::OP_POLL) begin
					next_r.st = fspc_pkg::S_SETUP;
				end else begin
					next_r.st = fspc_pkg::S_IDLE;
					next_r.op = fspc_pkg::OP_NONE;
				end
			end
		endcase

		// Load window runs out: the flash now programs on its own
		if (r.window_open && !(r.st == fspc_pkg::S_ACTIVE &&
			r.op == fspc_pkg::OP_LOAD)) begin
			if (r.win_cnt <= WIN_W'(1)) begin
				next_r.window_open = 1'b0;
				next_r.dev_busy = 1'b1;
			end else begin
				next_r.win_cnt = r.win_cnt - 1'b1;
			end
		end
	end

	// State register
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			r <= '0;
			r.addr <= fspc_pkg::ADDR_RESET;
			r.wdata <= fspc_pkg::WDATA_RESET;
			r.pwr_cnt <= PW_W'(POWER_WAIT_CYC);
			r.hreadyout <= 1'b1;
			r.ce_n <= 1'b1;
			r.oe_n <= 1'b1;
			r.we_n <= 1'b1;
		end else begin
			r <= next_r;
		end
	end

	// Outputs straight from the state register
	assign hreadyout = r.hreadyout;
	assign hrdata = r.hrdata;
	assign hresp = r.hresp;
	assign flash_ce_n = r.ce_n;
	assign flash_oe_n = r.oe_n;
	assign flash_we_n = r.we_n;
	assign flash_addr = r.fa;
	assign flash_dq_out = r.dq_out;
	assign flash_dq_oe = r.dq_oe;

	// Checks on the pin behaviour
	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);

	a_strobe_with_select: assert property (
		!flash_we_n |-> !flash_ce_n && flash_oe_n && flash_dq_oe)
		else $error("write strobe low without select or with enable");

	a_strobe_width: assert property (
		$fell(flash_we_n) |-> (!flash_we_n)[*3] ##1 flash_we_n)
		else $error("write strobe low time wrong");

	a_data_hold: assert property (
		$rose(flash_we_n) |-> flash_dq_oe && !flash_ce_n && $stable(flash_dq_out))
		else $error("data or select lost at strobe rise");

	a_no_contention: assert property (
		$fell(flash_oe_n) |->
		(!flash_oe_n && !flash_ce_n && !flash_dq_oe)[*4] ##1 flash_oe_n)
		else $error("read enable too short or host drives data");

	a_sector_held: assert property (
		$fell(flash_we_n) && $past(r.window_open) |->
		flash_addr[15:7] == $past(r.sector))
		else $error("sector changed inside a load sequence");

	a_window_close: assert property (
		r.window_open && r.win_cnt == WIN_W'(1) && r.st == fspc_pkg::S_IDLE
		|=> !r.window_open && r.dev_busy)
		else $error("load window expiry not tracked");

	a_no_load_busy: assert property (
		$fell(flash_we_n) |-> !r.dev_busy)
		else $error("load strobed while flash is programming");

	a_power_wait: assert property (
		$fell(flash_we_n) |-> r.pwr_cnt == '0)
		else $error("load strobed during power-up hold-off");

	a_read_refused: assert property (
		r.wr_pend && r.wr_addr == fspc_pkg::REG_CMD && hwdata[1:0] == 2'h1
		&& r.dev_busy |=> r.err_refused && r.st == fspc_pkg::S_IDLE ##1 flash_oe_n)
		else $error("read started while flash is busy");

endmodule

`default_nettype wire

//--- inc/fspc_pkg.sv
// Constants, types and register map of the flash sector program host.
// Assumes one 25 MHz clock and a 16-bit parallel flash on plain pins.
// Contract
// - Host strobes write low, select low, enable high
// - Next load within 150 us, else programming
// - Host holds sector number on upper lines
// - Lock enabled by three ordinary load commands
// - Locked device needs unlock before each load
// - Six-step command sequence erases whole chip

package fspc_pkg;

	// Clock and pin timing
	localparam int CLK_PERIOD_NS = 40;
	localparam int READ_ACCESS_NS = 150;
	localparam int READ_CYC = (READ_ACCESS_NS + CLK_PERIOD_NS - 1) /
		CLK_PERIOD_NS;
	localparam int STROBE_LOW_NS = 100;
	localparam int STROBE_CYC = (STROBE_LOW_NS + CLK_PERIOD_NS - 1) /
		CLK_PERIOD_NS;
	localparam int LOAD_WINDOW_US = 150;
	localparam int LOAD_WINDOW_CYC = LOAD_WINDOW_US * 1000 / CLK_PERIOD_NS;
	localparam int LOAD_MARGIN_CYC = 4;
	localparam int POWER_WAIT_MS = 5;
	localparam int POWER_WAIT_CYC = POWER_WAIT_MS * 1000000 / CLK_PERIOD_NS;
	localparam int POLL_LIMIT_MS = 20;
	localparam int POLL_LIMIT_CYC = POLL_LIMIT_MS * 1000000 / CLK_PERIOD_NS;

	// Flash geometry
	localparam int WORD_W = 16;
	localparam int FLASH_ADDR_W = 16;
	localparam int SECTOR_LSB = 7;
	localparam int SECTOR_W = 9;
	localparam int TOGGLE_BIT_LOW_BYTE = 6;
	localparam int TOGGLE_BIT_HIGH_BYTE = 14;

	// Register byte offsets
	localparam logic [7:0] REG_CMD = 8'h00;
	localparam logic [7:0] REG_ADDR = 8'h04;
	localparam logic [7:0] REG_WDATA = 8'h08;
	localparam logic [7:0] REG_RDATA = 8'h0c;
	localparam logic [7:0] REG_STATUS = 8'h10;

	// Status bit positions
	localparam int ST_BUSY = 0;
	localparam int ST_WINDOW = 1;
	localparam int ST_DEV_BUSY = 2;
	localparam int ST_POWER_WAIT = 3;
	localparam int ST_ERR_REFUSED = 4;
	localparam int ST_ERR_TIMEOUT = 5;

	// Reset values
	localparam logic [15:0] ADDR_RESET = 16'h0000;
	localparam logic [15:0] WDATA_RESET = 16'hffff;

	typedef enum logic [1:0] {
		OP_NONE = 2'h0,
		OP_READ = 2'h1,
		OP_LOAD = 2'h2,
		OP_POLL = 2'h3
	} fspc_op_type;

	typedef enum logic [1:0] {
		S_IDLE = 2'b00,
		S_SETUP = 2'b01,
		S_ACTIVE = 2'b11,
		S_FINISH = 2'b10
	} fspc_state_type;

endpackage

//--- hdl/fspc_timer.sv
// Down counter that times each strobe phase of the flash pins.
// Assumes a load pulse from the sequencer in the cycle before the phase.
`timescale 1ns/1ps
`default_nettype none

module fspc_timer #(
	parameter int W = 3
) (
	input wire logic hclk, // System clock
	input wire logic hresetn, // Asynchronous reset, active low
	input wire logic load, // Start a new phase
	input wire logic [W-1:0] value, // Phase length minus one
	output logic expired // Count has reached zero
);

	typedef struct packed {
		logic [W-1:0] cnt;
	} fspc_timer_state_type;

	fspc_timer_state_type r;
	fspc_timer_state_type next_r;

	// Reload or count down towards zero
	always_comb begin
		next_r = r;
		if (load) begin
			next_r.cnt = value;
		end else if (r.cnt != '0) begin
			next_r.cnt = r.cnt - 1'b1;
		end
	end

	// State register
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			r <= '0;
		end else begin
			r <= next_r;
		end
	end

	assign expired = (r.cnt == '0);

endmodule

`default_nettype wire

//--- dv/fspc_flash_model.sv
// Behavioural sector flash that answers the host controller's pins.
// Assumes the host moves its pins only just after its clock edges.
`timescale 1ns/1ps
`default_nettype none

module fspc_flash_model #(
	parameter int PROG_NS = 20000
) (
	input wire logic ce_n, // Chip select
	input wire logic oe_n, // Output enable
	input wire logic we_n, // Write strobe
	input wire logic [15:0] addr, // Word address
	input wire logic [15:0] dq_h, // Host data
	input wire logic dq_oe, // Host drives data
	output logic [15:0] dq // Level on the wire
);
	logic [15:0] mem [0:65535];
	logic [15:0] lat [0:127];
	logic [127:0] vld;
	logic [8:0] sec;
	logic [6:0] wp;
	logic [15:0] last, val, hold;
	logic busy, tog, loading;
	logic armed, locked;
	realtime t_up, t_dn;
	wire stb_n = ce_n | we_n;
	wire rd_on = !ce_n && !oe_n && we_n;
	wire drv = dq_oe | rd_on;

	// Array preset to an address pattern
	initial begin
		for (int i = 0; i < 65536; i++)
			mem[i] = i[15:0] ^ 16'h5a5a;
		vld = '0;
		busy = 0;
		tog = 0;
		loading = 0;
		hold = '0;
		t_up = 0;
		t_dn = 0;
		armed = 0;
		locked = 0; // Starts off; no enable code is modelled
	end

	// Address on the later falling edge, only with enable high
	always @(negedge stb_n) begin
		if (oe_n && !busy) begin
			{sec, wp} = addr;
			t_dn = $realtime;
			armed = 1;
		end
	end

	// Data on the first rising edge; short glitches leave no trace
	always @(posedge stb_n) begin
		if (armed && $realtime - t_dn >= 15.0) begin
			lat[wp] = dq;
			vld[wp] = 1'b1;
			last = dq;
			t_up = $realtime;
			loading = 1;
		end
		armed = 0;
	end

	// Quiet window ends loading, then erase and program
	always begin
		#10;
		if (loading && stb_n && $realtime - t_up >= 150000.0) begin
			loading = 0;
			busy = 1;
			#(PROG_NS);
			// A locked write only runs the timer
			if (!locked) begin
				for (int i = 0; i < 128; i++)
					mem[{sec, i[6:0]}] = vld[i] ? lat[i] : 16'hffff;
			end
			vld = '0;
			busy = 0;
		end
	end

	// Each read while busy flips the toggle bits
	always @(posedge rd_on) begin
		if (busy)
			tog = ~tog;
	end

	// Host data while driven, polling word while busy, stored word otherwise
	always @* begin
		if (dq_oe)
			val = dq_h;
		else if (busy)
			val = {~last[15], tog, last[13:8], ~last[7], tog, last[5:0]};
		else
			val = mem[addr];
	end

	// Released wire shows the inverse of its last level
	always @* begin
		if (drv)
			hold = val;
	end
	assign dq = drv ? val : ~hold;
endmodule
`default_nettype wire

//--- dv/fspc_host_tb.sv
// Self-checking bench for the flash host, driven over AHB-Lite.
// Assumes the flash model answers the pins with a short program time.
`timescale 1ns/1ps
`default_nettype none

module fspc_host_tb;
	localparam logic [7:0] r_cmd = fspc_pkg::REG_CMD;
	localparam logic [7:0] r_adr = fspc_pkg::REG_ADDR;
	localparam logic [7:0] r_wd = fspc_pkg::REG_WDATA;
	localparam logic [7:0] r_rd = fspc_pkg::REG_RDATA;
	localparam logic [7:0] r_st = fspc_pkg::REG_STATUS;
	logic hclk = 0;
	logic hresetn = 0;
	logic hsel = 0;
	logic hwrite = 0;
	logic [1:0] htrans = '0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] haddr = '0;
	logic [31:0] hwdata = '0;
	logic [31:0] hrdata, rd;
	logic hreadyout, hresp, ce_n, oe_n, we_n, dq_oe;
	logic [15:0] fa, dq_out, dq_in;
	logic [15:0] ra [6] = '{16'h0283, 16'h0280, 16'h02ff, 16'h0281,
		16'h0481, 16'h0300};
	logic [15:0] rx [6] = '{16'h00aa, 16'h8040, 16'h4c3e, 16'hffff,
		16'h5edb, 16'h595a};
	int n_fail = 0;
	int n_checks = 0;

	// Clock
	always #20 hclk = ~hclk;

	fspc_host #(.POWER_WAIT_CYC(20), .POLL_LIMIT_CYC(2000)) fspc_host_inst (
		.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
		.hready(hreadyout), .hreadyout, .hrdata, .hresp,
		.flash_ce_n(ce_n), .flash_oe_n(oe_n), .flash_we_n(we_n),
		.flash_addr(fa), .flash_dq_in(dq_in), .flash_dq_out(dq_out),
		.flash_dq_oe(dq_oe));

	fspc_flash_model fspc_flash_model_inst (.ce_n, .oe_n, .we_n,
		.addr(fa), .dq_h(dq_out), .dq_oe, .dq(dq_in));

	task automatic test_done();
		if (n_fail == 0 && n_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen,
				exp);
		end
	endtask

	// Edges until hready is sampled high, bounded
	task automatic wait_rdy();
		int k;
		k = 0;
		do begin
			@(posedge hclk);
			k++;
		end while (hreadyout !== 1'b1 && k < 100);
		if (hreadyout !== 1'b1) begin
			n_fail++;
			test_done();
		end
	endtask

	// One single word transfer
	task automatic xfer(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		hsel <= 1'b1;
		htrans <= 2'b10;
		hwrite <= w;
		haddr <= {24'h0, a};
		wait_rdy();
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= d;
		wait_rdy();
		rd = hrdata;
	endtask

	// Read status until the masked bits match
	task automatic wait_st(input logic [31:0] m, input logic [31:0] v);
		int k;
		for (k = 0; k < 3000; k++) begin
			xfer(0, r_st, 0);
			if ((rd & m) === v)
				break;
		end
		if (k == 3000) begin
			n_fail++;
			test_done();
		end
	endtask

	task automatic cmd(input logic [15:0] a, input logic [1:0] op);
		xfer(1, r_adr, {16'h0, a});
		xfer(1, r_cmd, {30'h0, op});
	endtask

	task automatic load(input logic [15:0] a, input logic [15:0] d);
		xfer(1, r_wd, {16'h0, d});
		cmd(a, 2'h2);
		wait_st(32'h1, 32'h0);
	endtask

	// Main sequence
	initial begin
		repeat (3) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		xfer(0, r_st, 0);
		check(rd, 32'h8);
		check({31'h0, hresp}, 32'h0);
		xfer(0, r_wd, 0);
		check(rd, 32'hffff);
		xfer(1, 8'h14, 32'h1234_5678);
		xfer(0, 8'h14, 0);
		check(rd, 32'h0);
		xfer(1, r_cmd, 32'h2);
		xfer(0, r_st, 0);
		check(rd & 32'h11, 32'h10);
		check({31'h0, ce_n}, 32'h1);
		wait_st(32'h8, 32'h0);
		xfer(1, r_st, 32'h10);
		cmd(16'h1234, 2'h1);
		wait_st(32'h1, 32'h0);
		xfer(0, r_rd, 0);
		check(rd, 32'h486e);
		// Words of sector 5 out of order
		load(16'h0283, 16'h00aa);
		load(16'h0280, 16'h8040);
		load(16'h02ff, 16'h4c3e);
		cmd(16'h0481, 2'h2);
		xfer(0, r_st, 0);
		check(rd & 32'h13, 32'h12);
		xfer(1, r_st, 32'h10);
		wait_st(32'h6, 32'h4);
		cmd(16'h02ff, 2'h1);
		xfer(0, r_st, 0);
		check(rd & 32'h11, 32'h10);
		xfer(1, r_st, 32'h10);
		cmd(16'h02ff, 2'h3);
		wait_st(32'h1, 32'h0);
		check(rd & 32'h34, 32'h0);
		xfer(0, r_rd, 0);
		check(rd, 32'h4c3e);
		for (int i = 0; i < 6; i++) begin
			cmd(ra[i], 2'h1);
			wait_st(32'h1, 32'h0);
			xfer(0, r_rd, 0);
			check(rd, {16'h0, rx[i]});
		end
		test_done();
	end

	// Run limit
	initial begin
		repeat (100000) @(posedge hclk);
		n_fail++;
		test_done();
	end
endmodule
`default_nettype wire
